/* hw/srpom_map.vh */
`ifndef SRPOM_MAP_VH
`define SRPOM_MAP_VH
// ----------------------------------------
// Register word addresses.
// ----------------------------------------
`define SRPOM_A_CTRL 5'h00
`define SRPOM_A_B1 5'h01
`define SRPOM_A_B2 5'h02
`define SRPOM_A_LFEBE 5'h03
`define SRPOM_A_K1K2 5'h04
`define SRPOM_A_ROLL 5'h05
`define SRPOM_A_STAT 5'h06
`define SRPOM_G_MISC 3'h0
`define SRPOM_G_MISC2 3'h1
`define SRPOM_G_PTR 3'h2
`define SRPOM_G_B3 3'h3
`define SRPOM_G_PFEBE 3'h4
`define SRPOM_G_C2 3'h5
// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define SRPOM_CTRL_CONC 0
`define SRPOM_ROLL_B1 0
`define SRPOM_ROLL_B2 1
`define SRPOM_ROLL_LF 2
`define SRPOM_CTRL_RST 1'h0
`define SRPOM_SEED 7'h7F
// ----------------------------------------
// Frame geometry and overhead positions.
// ----------------------------------------
`define SRPOM_ROW_LAST 4'h8
`define SRPOM_COL_LAST 11'h0437
`define SRPOM_STS_LAST 4'hB
`define SRPOM_TOH_COLS 11'h0024
`define SRPOM_ROW_B1 4'h1
`define SRPOM_ROW_PTR 4'h3
`define SRPOM_ROW_B2 4'h4
`define SRPOM_ROW_Z2 4'h8
`define SRPOM_COL_K1 11'h000C
`define SRPOM_COL_K2 11'h0018
`define SRPOM_COL_Z2 11'h000E
`define SRPOM_U_CONC 11'h000C
`define SRPOM_U_CH 11'h0003
`define SRPOM_STRIDE_CONC 14'h0414
`define SRPOM_STRIDE_CH 14'h0105
// ----------------------------------------
// Pointer and label constants.
// ----------------------------------------
`define SRPOM_MAX_PTR 10'h030E
`define SRPOM_EVEN_MASK 10'h0155
`define SRPOM_ODD_MASK 10'h02AA
`define SRPOM_JUST_MIN 4'h8
`define SRPOM_PERSIST 2'h3
`define SRPOM_AIS_FRAMES 2'h3
`define SRPOM_C2_LABEL 8'h13
`define SRPOM_Z2_LIMIT 8'h61
`define SRPOM_G1_LIMIT 4'h9
`endif

/* hw/srpom_rx.v */
// Summary of operation
// - Pointer invalid if above 782, not held three frames, or new data flag set.
// - Pointer value is H1 bits one to zero above all eight H2 bits.
// - New data flag when H1 bits seven to four are 0001,1000,1001,1011,1101.
// - New data flag with in-range pointer replaces current pointer at once, first priority.
// - Three identical valid pointers replace the current pointer, second priority.
// - Positive justification when even-inverted pointer agrees in eight bits with inverted current.
// - Negative justification when odd-inverted pointer agrees in eight bits with inverted current.
// - Four pointers in four-channel mode, one pointer in concatenated mode.
// - B1 parity over whole scrambled frame, checked against next B1, bit errors counted.
// - B1 counting stops during frame, signal or delineation alarms.
// - H3 bytes carry payload only in a negative justification frame.
// - B2 parity per lane over line overhead and payload, checked and counted.
// - B2 counting and line far-end feedback stop during line alarms.
// - K1 and K2 are stored for software, no protection switching.
// - Third Z2 byte below 97 is added to line far-end count, overflow sticky.
// - Line far-end counting stops during line alarms.
// - B3 parity over each envelope, checked against next B3, overflow sticky.
// - B3 and path feedback stop under line alarms, pointer loss or path alarm.
// - C2 label differing from 0x13 counts in three bits, overflow sticky.
// - C2 counting stops under line alarms, pointer loss or path alarm.
// - G1 far-end value below 9 is counted, overflow sticky, path alarms halt it.
// - Counters never clear on read; sticky roll-over bits cleared by software.
// - Path alarm after three all-ones pointer frames, cleared by three valid pointers.
`timescale 1ns/1ns
`include "srpom_map.vh"
module srpom_rx
(
    input wire CLOCK,
    input wire RST,
    input wire [7:0] DATA,
    input wire DATA_VALID,
    input wire FRAME_START,
    input wire OOF,
    input wire LOF,
    input wire LOS,
    input wire [3:0] CELL_DELINEATION_LOSS,
    input wire [3:0] LOP,
    input wire [4:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    output reg [7:0] SPE_DATA,
    output reg SPE_VALID,
    output reg [1:0] SPE_CHANNEL,
    output reg SPE_START
);
// ----------------------------------------
// Helper functions.
// ----------------------------------------
function [3:0] popc;
    input [11:0] v;
    integer k;
    begin
        popc = 4'h0;
        for (k = 0; k < 12; k = k + 1)
        begin
            popc = popc + {3'h0, v[k]};
        end
    end
endfunction
function [14:0] dstep;
    input [6:0] s;
    integer k;
    reg [6:0] t;
    reg [7:0] key;
    begin
        t = s;
        key = 8'h00;
        for (k = 7; k >= 0; k = k - 1)
        begin
            key[k] = t[6];
            t = {t[5:0], t[6] ^ t[5]};
        end
        dstep = {t, key};
    end
endfunction
// ----------------------------------------
// State.
// ----------------------------------------
integer i;
reg [3:0] row_reg;
reg [10:0] col_reg;
reg [3:0] s_reg;
reg framed_reg;
reg [6:0] scr_reg;
reg ctrl_reg;
reg [15:0] roll_reg;
reg [15:0] k_reg;
reg [15:0] b1_cnt_reg;
reg [15:0] b2_cnt_reg;
reg [15:0] lf_cnt_reg;
reg [7:0] b1_acc_reg;
reg [7:0] b1_prev_reg;
reg b1_ok_reg;
reg b2_ok_reg;
reg [7:0] b2_acc_reg [0:11];
reg [7:0] b2_prev_reg [0:11];
reg [9:0] cur_ptr_reg [0:3];
reg [9:0] last_ptr_reg [0:3];
reg [1:0] same_reg [0:3];
reg [1:0] ais_cnt_reg [0:3];
reg [7:0] h1_reg [0:3];
reg [13:0] off_reg [0:3];
reg [13:0] spe_reg [0:3];
reg [7:0] b3_acc_reg [0:3];
reg [7:0] b3_prev_reg [0:3];
reg [15:0] b3_cnt_reg [0:3];
reg [15:0] pf_cnt_reg [0:3];
reg [2:0] c2_cnt_reg [0:3];
reg [3:0] ais_reg;
reg [3:0] pos_reg;
reg [3:0] neg_reg;
reg [3:0] ndf_reg;
reg [3:0] in_spe_reg;
reg [3:0] b3_ok_reg;
// ----------------------------------------
// Byte position and descrambling.
// ----------------------------------------
wire byte_ok = DATA_VALID & (framed_reg | FRAME_START);
wire [3:0] row = FRAME_START ? 4'h0 : row_reg;
wire [10:0] col = FRAME_START ? 11'h000 : col_reg;
wire [3:0] sts = FRAME_START ? 4'h0 : s_reg;
wire conc = ctrl_reg;
wire [1:0] ch = conc ? 2'h0 : col[1:0];
wire [10:0] cc = conc ? col : {2'h0, col[10:2]};
wire [10:0] u = conc ? `SRPOM_U_CONC : `SRPOM_U_CH;
wire [13:0] stride = conc ? `SRPOM_STRIDE_CONC : `SRPOM_STRIDE_CH;
wire toh = col < `SRPOM_TOH_COLS;
wire soh = toh & (row < `SRPOM_ROW_PTR);
wire clear_row = toh & (row == 4'h0);
wire [6:0] scr_use = clear_row ? `SRPOM_SEED : scr_reg;
wire [14:0] ds = dstep(scr_use);
wire [7:0] dsc = clear_row ? DATA : DATA ^ ds[7:0];
wire prow = row == `SRPOM_ROW_PTR;
wire is_h1 = prow & (cc == 11'h000);
wire is_h2 = prow & (cc == u);
wire is_h3 = prow & (cc >= 2 * u) & (cc < 3 * u);
wire first_h3 = prow & (cc == 2 * u);
wire pay = cc >= 3 * u;
wire stuff = pos_reg[ch] & prow & pay & (cc < 4 * u);
wire dv = byte_ok & ((pay & ~stuff) | (is_h3 & neg_reg[ch]));
wire lin = OOF | LOF | LOS | (|CELL_DELINEATION_LOSS);
wire pin = lin | LOP[ch] | ais_reg[ch];
// ----------------------------------------
// Pointer interpretation.
// ----------------------------------------
wire [7:0] h1 = h1_reg[ch];
wire [9:0] rxp = {h1[1:0], dsc};
wire [9:0] curp = cur_ptr_reg[ch];
wire ndf = (h1[7:4] == 4'b0001) | (h1[7:4] == 4'b1000) | (h1[7:4] == 4'b1001) |
           (h1[7:4] == 4'b1011) | (h1[7:4] == 4'b1101);
wire inr = rxp <= `SRPOM_MAX_PTR;
wire [1:0] same_nx = (rxp != last_ptr_reg[ch]) ? 2'h1 :
                     (same_reg[ch] == `SRPOM_PERSIST) ? `SRPOM_PERSIST : same_reg[ch] + 2'h1;
wire valid3 = inr & ~ndf & (same_nx == `SRPOM_PERSIST);
wire all1 = (h1 == 8'hFF) & (dsc == 8'hFF);
wire [3:0] agree_p = popc({2'h0, rxp ^ `SRPOM_EVEN_MASK ^ curp});
wire [3:0] agree_n = popc({2'h0, rxp ^ `SRPOM_ODD_MASK ^ curp});
wire jok = ~ndf & ~valid3 & ~ais_reg[ch] & ~all1;
wire pj = jok & (agree_p >= `SRPOM_JUST_MIN);
wire nj = jok & (agree_n >= `SRPOM_JUST_MIN);
// ----------------------------------------
// Envelope tracking.
// ----------------------------------------
wire [13:0] rpos = first_h3 ? 14'h0000 : off_reg[ch];
wire [13:0] j1_off = (curp + 14'h0001) * u[3:0];
wire is_j1 = dv & (rpos == j1_off);
wire [13:0] sp = is_j1 ? 14'h0000 : spe_reg[ch] + 14'h0001;
wire in_spe = dv & in_spe_reg[ch] & ~is_j1;
// ----------------------------------------
// Error events and counter sums.
// ----------------------------------------
wire [3:0] b1_err = popc({4'h0, dsc ^ b1_prev_reg});
wire [16:0] b1_sum = {1'b0, b1_cnt_reg} + {13'h0000, b1_err};
wire e_b1 = byte_ok & (row == `SRPOM_ROW_B1) & (col == 11'h000) & b1_ok_reg & ~lin;
wire [3:0] b2_err = popc({4'h0, dsc ^ b2_prev_reg[sts]});
wire [16:0] b2_sum = {1'b0, b2_cnt_reg} + {13'h0000, b2_err};
wire e_b2 = byte_ok & (row == `SRPOM_ROW_B2) & (col < 11'h00C) & b2_ok_reg & ~lin;
wire [16:0] lf_sum = {1'b0, lf_cnt_reg} + {9'h000, dsc};
wire e_lf = byte_ok & (row == `SRPOM_ROW_Z2) & (col == `SRPOM_COL_Z2) &
            (dsc < `SRPOM_Z2_LIMIT) & ~lin;
wire [3:0] b3_err = popc({4'h0, dsc ^ b3_prev_reg[ch]});
wire [16:0] b3_sum = {1'b0, b3_cnt_reg[ch]} + {13'h0000, b3_err};
wire e_b3 = in_spe & (sp == stride) & b3_ok_reg[ch] & ~pin;
wire [3:0] c2_sum = {1'b0, c2_cnt_reg[ch]} + 4'h1;
wire e_c2 = in_spe & (sp == 2 * stride) & (dsc != `SRPOM_C2_LABEL) & ~pin;
wire [16:0] pf_sum = {1'b0, pf_cnt_reg[ch]} + {13'h0000, dsc[7:4]};
wire e_pf = in_spe & (sp == 3 * stride) & (dsc[7:4] < `SRPOM_G1_LIMIT) & ~pin;
reg [15:0] roll_set;
reg [15:0] rd_val;
always @*
begin
    roll_set = 16'h0000;
    roll_set[`SRPOM_ROLL_B1] = e_b1 & b1_sum[16];
    roll_set[`SRPOM_ROLL_B2] = e_b2 & b2_sum[16];
    roll_set[`SRPOM_ROLL_LF] = e_lf & lf_sum[16];
    roll_set[4 + ch] = e_b3 & b3_sum[16];
    roll_set[8 + ch] = e_c2 & c2_sum[3];
    roll_set[12 + ch] = e_pf & pf_sum[16];
end
always @*
begin
    rd_val = 16'h0000;
    case (ADDR[4:2])
        `SRPOM_G_MISC:
        begin
            case (ADDR[1:0])
                2'h0: rd_val = {15'h0000, ctrl_reg};
                2'h1: rd_val = b1_cnt_reg;
                2'h2: rd_val = b2_cnt_reg;
                default: rd_val = lf_cnt_reg;
            endcase
        end
        `SRPOM_G_MISC2:
        begin
            case (ADDR[1:0])
                2'h0: rd_val = k_reg;
                2'h1: rd_val = roll_reg;
                2'h2: rd_val = {ndf_reg, neg_reg, pos_reg, ais_reg};
                default: rd_val = 16'h0000;
            endcase
        end
        `SRPOM_G_PTR: rd_val = {6'h00, cur_ptr_reg[ADDR[1:0]]};
        `SRPOM_G_B3: rd_val = b3_cnt_reg[ADDR[1:0]];
        `SRPOM_G_PFEBE: rd_val = pf_cnt_reg[ADDR[1:0]];
        `SRPOM_G_C2: rd_val = {13'h0000, c2_cnt_reg[ADDR[1:0]]};
        default: rd_val = 16'h0000;
    endcase
end
// ----------------------------------------
// Register port.
// ----------------------------------------
always @(posedge CLOCK or posedge RST)
begin
    if (RST)
    begin
        RDATA <= 16'h0000;
        ctrl_reg <= `SRPOM_CTRL_RST;
        roll_reg <= 16'h0000;
    end
    else
    begin
        RDATA <= RD ? rd_val : 16'h0000;
        if (WR && ADDR == `SRPOM_A_CTRL)
        begin
            ctrl_reg <= WDATA[`SRPOM_CTRL_CONC];
        end
        if (WR && ADDR == `SRPOM_A_ROLL)
        begin
            roll_reg <= (roll_reg & ~WDATA) | roll_set;
        end
        else
        begin
            roll_reg <= roll_reg | roll_set;
        end
    end
end
// ----------------------------------------
// Frame datapath.
// ----------------------------------------
always @(posedge CLOCK or posedge RST)
begin
    if (RST)
    begin
        row_reg <= 4'h0;
        col_reg <= 11'h000;
        s_reg <= 4'h0;
        framed_reg <= 1'b0;
        scr_reg <= `SRPOM_SEED;
        k_reg <= 16'h0000;
        b1_cnt_reg <= 16'h0000;
        b2_cnt_reg <= 16'h0000;
        lf_cnt_reg <= 16'h0000;
        b1_acc_reg <= 8'h00;
        b1_prev_reg <= 8'h00;
        b1_ok_reg <= 1'b0;
        b2_ok_reg <= 1'b0;
        ais_reg <= 4'h0;
        pos_reg <= 4'h0;
        neg_reg <= 4'h0;
        ndf_reg <= 4'h0;
        in_spe_reg <= 4'h0;
        b3_ok_reg <= 4'h0;
        SPE_DATA <= 8'h00;
        SPE_VALID <= 1'b0;
        SPE_CHANNEL <= 2'h0;
        SPE_START <= 1'b0;
        for (i = 0; i < 12; i = i + 1)
        begin
            b2_acc_reg[i] <= 8'h00;
            b2_prev_reg[i] <= 8'h00;
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            cur_ptr_reg[i] <= 10'h000;
            last_ptr_reg[i] <= 10'h000;
            same_reg[i] <= 2'h0;
            ais_cnt_reg[i] <= 2'h0;
            h1_reg[i] <= 8'h00;
            off_reg[i] <= 14'h0000;
            spe_reg[i] <= 14'h0000;
            b3_acc_reg[i] <= 8'h00;
            b3_prev_reg[i] <= 8'h00;
            b3_cnt_reg[i] <= 16'h0000;
            pf_cnt_reg[i] <= 16'h0000;
            c2_cnt_reg[i] <= 3'h0;
        end
    end
    else
    begin
        SPE_VALID <= dv;
        SPE_START <= is_j1;
        if (dv)
        begin
            SPE_DATA <= dsc;
            SPE_CHANNEL <= ch;
        end
        if (byte_ok)
        begin
            framed_reg <= 1'b1;
            scr_reg <= ds[14:8];
            col_reg <= (col == `SRPOM_COL_LAST) ? 11'h000 : col + 11'h001;
            s_reg <= (sts == `SRPOM_STS_LAST) ? 4'h0 : sts + 4'h1;
            if (col == `SRPOM_COL_LAST)
            begin
                row_reg <= (row == `SRPOM_ROW_LAST) ? 4'h0 : row + 4'h1;
            end
            if (FRAME_START)
            begin
                b1_prev_reg <= b1_acc_reg;
                b1_acc_reg <= DATA;
                b1_ok_reg <= framed_reg;
                b2_ok_reg <= framed_reg;
                for (i = 0; i < 12; i = i + 1)
                begin
                    b2_prev_reg[i] <= b2_acc_reg[i];
                    b2_acc_reg[i] <= 8'h00;
                end
            end
            else
            begin
                b1_acc_reg <= b1_acc_reg ^ DATA;
                if (!soh)
                begin
                    b2_acc_reg[sts] <= b2_acc_reg[sts] ^ dsc;
                end
            end
            if (e_b1)
            begin
                b1_cnt_reg <= b1_sum[15:0];
            end
            if (e_b2)
            begin
                b2_cnt_reg <= b2_sum[15:0];
            end
            if (e_lf)
            begin
                lf_cnt_reg <= lf_sum[15:0];
            end
            if (row == `SRPOM_ROW_B2 && col == `SRPOM_COL_K1)
            begin
                k_reg[15:8] <= dsc;
            end
            if (row == `SRPOM_ROW_B2 && col == `SRPOM_COL_K2)
            begin
                k_reg[7:0] <= dsc;
            end
            if (is_h1)
            begin
                h1_reg[ch] <= dsc;
            end
            if (is_h2)
            begin
                last_ptr_reg[ch] <= rxp;
                same_reg[ch] <= same_nx;
                ndf_reg[ch] <= ndf;
                pos_reg[ch] <= pj;
                neg_reg[ch] <= nj;
                if (ndf && inr)
                begin
                    cur_ptr_reg[ch] <= rxp;
                end
                else if (valid3)
                begin
                    cur_ptr_reg[ch] <= rxp;
                end
                else if (pj)
                begin
                    cur_ptr_reg[ch] <= (curp == `SRPOM_MAX_PTR) ? 10'h000 : curp + 10'h001;
                end
                else if (nj)
                begin
                    cur_ptr_reg[ch] <= (curp == 10'h000) ? `SRPOM_MAX_PTR : curp - 10'h001;
                end
                if (all1)
                begin
                    ais_cnt_reg[ch] <= (ais_cnt_reg[ch] == `SRPOM_AIS_FRAMES) ? `SRPOM_AIS_FRAMES :
                                       ais_cnt_reg[ch] + 2'h1;
                    if (ais_cnt_reg[ch] == `SRPOM_AIS_FRAMES - 2'h1)
                    begin
                        ais_reg[ch] <= 1'b1;
                    end
                end
                else
                begin
                    ais_cnt_reg[ch] <= 2'h0;
                    if (valid3)
                    begin
                        ais_reg[ch] <= 1'b0;
                    end
                end
            end
            if (is_h3 || pay)
            begin
                off_reg[ch] <= rpos + 14'h0001;
            end
            if (dv)
            begin
                spe_reg[ch] <= sp;
                if (is_j1)
                begin
                    in_spe_reg[ch] <= 1'b1;
                    b3_ok_reg[ch] <= in_spe_reg[ch];
                    b3_prev_reg[ch] <= b3_acc_reg[ch];
                    b3_acc_reg[ch] <= dsc;
                end
                else
                begin
                    b3_acc_reg[ch] <= b3_acc_reg[ch] ^ dsc;
                end
            end
            if (e_b3)
            begin
                b3_cnt_reg[ch] <= b3_sum[15:0];
            end
            if (e_c2)
            begin
                c2_cnt_reg[ch] <= c2_sum[2:0];
            end
            if (e_pf)
            begin
                pf_cnt_reg[ch] <= pf_sum[15:0];
            end
        end
    end
end
endmodule // srpom_rx

/* dv/srpom_checker.sv */
`timescale 1ns/1ns
`include "srpom_map.vh"
// ----------------------------------------
// Port checker.
// ----------------------------------------
module srpom_checker
(
    input wire CLOCK,
    input wire RST,
    input wire DATA_VALID,
    input wire FRAME_START,
    input wire [4:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [15:0] RDATA,
    input wire SPE_VALID,
    input wire [1:0] SPE_CHANNEL,
    input wire SPE_START
);
    logic [3:0] row_reg;
    logic [10:0] col_reg;
    logic seen_reg;
    logic conc_reg;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // Tracks the frame position of the last byte taken.
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            row_reg <= 4'h0;
            col_reg <= 11'h000;
            seen_reg <= 1'h0;
            conc_reg <= 1'h0;
        end
        else
        begin
            if (WR && ADDR == `SRPOM_A_CTRL)
                conc_reg <= WDATA[`SRPOM_CTRL_CONC];
            if (DATA_VALID && FRAME_START)
            begin
                row_reg <= 4'h0;
                col_reg <= 11'h000;
                seen_reg <= 1'h1;
            end
            else if (DATA_VALID && col_reg == `SRPOM_COL_LAST)
            begin
                col_reg <= 11'h000;
                row_reg <= row_reg + 4'h1;
            end
            else if (DATA_VALID)
                col_reg <= col_reg + 11'h001;
        end
    end
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("Read data not zero outside a read.");
    unmapped_zero_a: assert property ($past(RD) && $past(ADDR) == 5'h1F |-> RDATA == 16'h0000)
        else $error("Unmapped address read not zero.");
    mode_readback_a: assert property ($past(RD) && $past(ADDR) == `SRPOM_A_CTRL
        |-> RDATA == {15'h0000, conc_reg})
        else $error("Mode register read back wrong.");
    count_kept_a: assert property ((RD && ADDR == `SRPOM_A_B1) ##3 (RD && ADDR == `SRPOM_A_B1)
        |=> RDATA == $past(RDATA, 3))
        else $error("Counter changed by a read.");
    spe_byte_a: assert property (SPE_VALID |-> $past(DATA_VALID))
        else $error("Envelope byte without a line byte.");
    spe_toh_a: assert property (SPE_VALID
        |-> col_reg >= `SRPOM_TOH_COLS || (row_reg == `SRPOM_ROW_PTR && col_reg >= 11'h018))
        else $error("Envelope byte from overhead column.");
    spe_chan_a: assert property (SPE_VALID && !conc_reg |-> SPE_CHANNEL == col_reg[1:0])
        else $error("Envelope channel wrong.");
    start_valid_a: assert property (SPE_START |-> SPE_VALID)
        else $error("Envelope start without byte.");
    before_frame_a: assert property (!seen_reg |-> !SPE_VALID && !SPE_START)
        else $error("Envelope output before first frame.");
endmodule // srpom_checker
bind srpom_rx srpom_checker u_srpom_checker
(
    .CLOCK(CLOCK), .RST(RST), .DATA_VALID(DATA_VALID), .FRAME_START(FRAME_START), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SPE_VALID(SPE_VALID), .SPE_CHANNEL(SPE_CHANNEL), .SPE_START(SPE_START)
);

/* dv/srpom_line_src.sv */
`timescale 1ns/1ns
`include "srpom_map.vh"
// ----------------------------------------
// Line byte source.
// ----------------------------------------
module srpom_line_src
(
    input wire clk,
    input wire rst,
    input wire run,
    input wire [39:0] ptrs,
    input wire [15:0] nibs,
    input wire [7:0] z2,
    input wire [7:0] k1,
    input wire [7:0] k2,
    input wire [7:0] b1_mask,
    output logic [7:0] data,
    output logic data_valid,
    output logic frame_start,
    output logic [3:0] row,
    output logic [10:0] col
);
    logic [6:0] lfsr_reg;
    logic [6:0] lfsr_next;
    logic [7:0] acc_reg;
    logic [7:0] bip_reg;
    logic [7:0] pl;
    logic [7:0] ks;
    logic [7:0] raw;
    logic bypass;
    logic first;
    logic last;
    int pi;
    int ni;
    // Plain byte of the position, then scrambled except in the row zero overhead columns.
    always_comb
    begin
        pi = 10 * int'(col[1:0]);
        ni = 4 * int'(col[1:0]);
        pl = 8'h00;
        if (row == `SRPOM_ROW_PTR && col < 11'h004)
            pl = {nibs[ni +: 4], 2'h0, ptrs[pi + 8 +: 2]};
        else if (row == `SRPOM_ROW_PTR && col >= 11'h00C && col < 11'h010)
            pl = ptrs[pi +: 8];
        else if (row == `SRPOM_ROW_B1 && col == 11'h000)
            pl = bip_reg ^ b1_mask;
        else if (row == `SRPOM_ROW_B2 && col == `SRPOM_COL_K1)
            pl = k1;
        else if (row == `SRPOM_ROW_B2 && col == `SRPOM_COL_K2)
            pl = k2;
        else if (row == `SRPOM_ROW_Z2 && col == `SRPOM_COL_Z2)
            pl = z2;
        bypass = row == 4'h0 && col < `SRPOM_TOH_COLS;
        lfsr_next = bypass ? `SRPOM_SEED : lfsr_reg;
        for (int i = 7; i >= 0; i--)
        begin
            ks[i] = lfsr_next[6];
            lfsr_next = {lfsr_next[5:0], lfsr_next[6] ^ lfsr_next[5]};
        end
        raw = bypass ? pl : pl ^ ks;
        first = row == 4'h0 && col == 11'h000;
        last = row == `SRPOM_ROW_LAST && col == `SRPOM_COL_LAST;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            row <= 4'h0;
            col <= 11'h000;
            data <= 8'h00;
            data_valid <= 1'h0;
            frame_start <= 1'h0;
            lfsr_reg <= `SRPOM_SEED;
            acc_reg <= 8'h00;
            bip_reg <= 8'h00;
        end
        else
        begin
            data_valid <= run;
            frame_start <= run && first;
            if (run)
            begin
                data <= raw;
                lfsr_reg <= lfsr_next;
                acc_reg <= first ? raw : acc_reg ^ raw;
                if (last)
                    bip_reg <= acc_reg ^ raw;
                col <= (col == `SRPOM_COL_LAST) ? 11'h000 : col + 11'h001;
                if (col == `SRPOM_COL_LAST)
                    row <= last ? 4'h0 : row + 4'h1;
            end
        end
    end
endmodule // srpom_line_src

/* dv/srpom_rx_tb.sv */
`timescale 1ns/1ns
`include "srpom_map.vh"
`define CHK(g, e) \
    begin \
        tests_run = tests_run + 1; \
        if ((g) !== (e)) \
        begin \
            errors = errors + 1; \
            $display("BAD %0t got %h want %h", $time, (g), (e)); \
        end \
    end
module srpom_rx_tb;
    logic CLOCK = 1'h0;
    logic RST = 1'h1;
    logic OOF = 1'h0;
    logic [3:0] tie = 4'h0;
    logic [4:0] ADDR = 5'h00;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'h0;
    logic RD = 1'h0;
    logic run = 1'h0;
    logic [39:0] ptrs = {10'h258, 10'h190, 10'h0FA, 10'h064};
    logic [15:0] nibs = 16'h6666;
    logic [7:0] z2 = 8'h60;
    logic [7:0] b1_mask = 8'h00;
    wire [7:0] DATA;
    wire DATA_VALID;
    wire FRAME_START;
    wire [3:0] src_row;
    wire [10:0] src_col;
    wire [15:0] RDATA;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    srpom_rx u_srpom_rx (.CLOCK(CLOCK), .RST(RST), .DATA(DATA), .DATA_VALID(DATA_VALID), .FRAME_START(FRAME_START),
        .OOF(OOF), .LOF(tie[0]), .LOS(tie[1]), .CELL_DELINEATION_LOSS(tie), .LOP(tie), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SPE_DATA(), .SPE_VALID(), .SPE_CHANNEL(), .SPE_START());
    srpom_line_src u_srpom_line_src (.clk(CLOCK), .rst(RST), .run(run), .ptrs(ptrs), .nibs(nibs), .z2(z2),
        .k1(8'hA5), .k2(8'h5A), .b1_mask(b1_mask), .data(DATA), .data_valid(DATA_VALID), .frame_start(FRAME_START),
        .row(src_row), .col(src_col));
    initial forever #20 CLOCK = ~CLOCK;
    task tally_and_finish();
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge CLOCK)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            errors = errors + 1;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Bus and stream helpers.
    // ----------------------------------------
    task rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge CLOCK);
        RD <= 1'h1;
        ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'h0;
        #1;
        `CHK(RDATA & m, e)
        @(posedge CLOCK);
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        WR <= 1'h1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'h0;
    endtask
    task wait_at(input logic [3:0] r);
        @(posedge CLOCK);
        while (!(src_row === r && src_col === 11'h000))
            @(posedge CLOCK);
    endtask
    task ptrs_are(input logic [39:0] p);
        for (int k = 0; k < 4; k++)
            rd({`SRPOM_G_PTR, 2'(k)}, 16'hFFFF, {6'h00, p[k * 10 +: 10]});
    endtask
    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    task t_regs();
        rd(`SRPOM_A_CTRL, 16'hFFFF, 16'h0000);
        wr(`SRPOM_A_B1, 16'hFFFF);
        rd(`SRPOM_A_B1, 16'hFFFF, 16'h0000);
        wr(5'h1F, 16'hFFFF);
        rd(5'h1F, 16'hFFFF, 16'h0000);
        wr(`SRPOM_A_CTRL, 16'h0001);
        rd(`SRPOM_A_CTRL, 16'hFFFF, 16'h0001);
        wr(`SRPOM_A_CTRL, 16'h0000);
        ptrs_are(40'h00_0000_0000);
    endtask
    task t_persist();
        run <= 1'h1;
        wait_at(4'h0);
        wait_at(4'h0);
        rd(`SRPOM_A_K1K2, 16'hFFFF, 16'hA55A);
        rd({`SRPOM_G_PTR, 2'h0}, 16'hFFFF, 16'h0000);
        wait_at(4'h0);
        b1_mask <= 8'h03;
        rd({`SRPOM_G_PTR, 2'h1}, 16'hFFFF, 16'h0000);
        wait_at(4'h0);
        ptrs_are({10'h258, 10'h190, 10'h0FA, 10'h064});
        rd(`SRPOM_A_LFEBE, 16'hFFFF, 16'h0120);
    endtask
    task t_jump();
        b1_mask <= 8'h80;
        ptrs <= {10'h10D, 10'h03A, 10'h2BC, 10'h30F};
        nibs <= 16'h669D;
        z2 <= 8'h61;
        wait_at(4'h0);
        b1_mask <= 8'h00;
        rd(`SRPOM_A_B1, 16'hFFFF, 16'h0003);
        ptrs_are({10'h257, 10'h191, 10'h2BC, 10'h064});
        rd(`SRPOM_A_STAT, 16'hFFF0, 16'h3840);
        rd(`SRPOM_A_LFEBE, 16'hFFFF, 16'h0120);
    endtask
    task t_ndf();
        ptrs <= {10'h028, 10'h01E, 10'h014, 10'h00A};
        nibs <= 16'hDB81;
        z2 <= 8'h32;
        wait_at(`SRPOM_ROW_Z2);
        OOF <= 1'h1;
        b1_mask <= 8'hFF;
        wait_at(4'h0);
        ptrs_are({10'h028, 10'h01E, 10'h014, 10'h00A});
        rd(`SRPOM_A_LFEBE, 16'hFFFF, 16'h0120);
    endtask
    task t_alarm();
        wait_at(4'h2);
        OOF <= 1'h0;
        b1_mask <= 8'h00;
        wait_at(4'h0);
        rd(`SRPOM_A_B1, 16'hFFFF, 16'h0003);
        rd(`SRPOM_A_B1, 16'hFFFF, 16'h0003);
        rd(`SRPOM_A_LFEBE, 16'hFFFF, 16'h0152);
    endtask
    task t_conc();
        wr(`SRPOM_A_CTRL, 16'h0001);
        ptrs <= {10'h028, 10'h01E, 10'h2B0, 10'h123};
        wait_at(4'h0);
        ptrs_are({10'h028, 10'h01E, 10'h014, 10'h123});
    endtask
    initial
    begin
        repeat (8) @(posedge CLOCK);
        RST <= 1'h0;
        t_regs();
        t_persist();
        t_jump();
        t_ndf();
        t_alarm();
        t_conc();
        tally_and_finish();
    end
endmodule // srpom_rx_tb
